//--- rtl/mrs_defs.svh
// Constants for the serial-bus coil and register slave
`ifndef MRS_DEFS_SVH
`define MRS_DEFS_SVH

// ----------------------------------------------------------------
// Function codes
// ----------------------------------------------------------------
`define MRS_FN_READ_COILS 8'h01
`define MRS_FN_READ_REGS 8'h03
`define MRS_FN_WRITE_COIL 8'h05
`define MRS_FN_EXC_FLAG 8'h80

// ----------------------------------------------------------------
// Exception codes
// ----------------------------------------------------------------
`define MRS_EXC_FUNCTION 8'h01
`define MRS_EXC_NOT_FOUND 8'h02
`define MRS_EXC_FORMAT 8'h03
`define MRS_EXC_NOT_AVAIL 8'h22

// ----------------------------------------------------------------
// Frame layout and limits
// ----------------------------------------------------------------
`define MRS_QUERY_LEN 4'h8
`define MRS_BROADCAST 8'h00
`define MRS_COIL_MAX 16'h001f
`define MRS_REG_MAX 16'h007d
`define MRS_COIL_ON 16'hff00
`define MRS_COIL_OFF 16'h0000
`define MRS_RUN_COIL 16'h0001
`define MRS_SRC_NETWORK 8'h03
`define MRS_EXC_LEN 8'h03
`define MRS_ECHO_LEN 8'h06
`define MRS_HDR_LEN 8'h03

// ----------------------------------------------------------------
// Frame check
// ----------------------------------------------------------------
`define MRS_CRC_INIT 16'hffff
`define MRS_CRC_POLY 16'ha001

`endif

//--- rtl/mrs_pkg.sv
// Types shared by the serial-bus coil and register slave
package mrs_pkg;
   typedef logic [7:0] mrs_byte_t;
   typedef logic [15:0] mrs_word_t;

   typedef enum logic [1:0] {
      MRS_ST_IDLE = 2'b00,
      MRS_ST_DECODE = 2'b01,
      MRS_ST_SEND = 2'b10
   } mrs_state_t;

   typedef enum logic [1:0] {
      MRS_RESP_EXC = 2'b00,
      MRS_RESP_COIL = 2'b01,
      MRS_RESP_REG = 2'b10,
      MRS_RESP_ECHO = 2'b11
   } mrs_resp_t;
endpackage : mrs_pkg

//--- rtl/mrs_crc16.sv
// Byte-serial frame check engine, reflected 16-bit generator
`timescale 1ns/1ps
`default_nettype none
`include "mrs_defs.svh"

module mrs_crc16 (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Byte stream
   input wire logic clear_i,
   input wire logic en_i,
   input wire mrs_pkg::mrs_byte_t data_i,
   // Result
   output mrs_pkg::mrs_word_t crc_o
);
   import mrs_pkg::*;

   mrs_word_t next_crc;

   always_comb begin
      next_crc = crc_o ^ {8'h00, data_i};
      for (int b = 0; b < 8; b++) begin
         if (next_crc[0]) begin
            next_crc = (next_crc >> 1) ^ `MRS_CRC_POLY;
         end else begin
            next_crc = next_crc >> 1;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         crc_o <= `MRS_CRC_INIT;
      end else if (clear_i) begin
         crc_o <= `MRS_CRC_INIT;
      end else if (en_i) begin
         crc_o <= next_crc;
      end
   end
endmodule : mrs_crc16
`default_nettype wire

//--- rtl/mrs_slave.sv
// Query interpreter for read coils, read registers and write single coil
//
// Summary of operation
// - Read-coil query: address, 01h, start coil, coil count, check word, in order.
// - Coil count zero or above thirty-one gets exception code 03h.
// - Read-coil reply: address, function, byte count, coil bytes, check word.
// - First requested coil sits in bit 0 of first data byte.
// - Coils outside the defined range read back as zero.
// - Coil wire address is coil number minus one.
// - Register number is received wire address plus one.
// - Read-register query 03h returns the requested count of consecutive words.
// - Register reply: address, function, byte count, words high byte first, check.
// - Write coil 05h: FF00h sets the coil, 0000h clears it.
// - Coil one run command acts only when source select equals 03.
// - Broadcast queries get no reply at all.
// - Requests that cannot be carried out get an exception reply.
// - Successful write-coil reply echoes the query unchanged.
// - Exception reply: function plus 80h, exception code, check word.
// - Check words use generator x16+x15+x2+1.
// - Queries for another slave address are ignored silently.
`timescale 1ns/1ps
`default_nettype none
`include "mrs_defs.svh"

module mrs_slave (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Configuration
   input wire mrs_pkg::mrs_byte_t slave_addr_i,
   input wire mrs_pkg::mrs_byte_t run_command_source_select_i,
   // Received byte stream
   input wire mrs_pkg::mrs_byte_t rx_byte_i,
   input wire logic rx_valid_i,
   input wire logic frame_end_i,
   // Transmitted byte stream
   output mrs_pkg::mrs_byte_t tx_byte_o,
   output logic tx_valid_o,
   output logic tx_last_o,
   input wire logic tx_ready_i,
   // Holding register read port
   output mrs_pkg::mrs_word_t reg_addr_o,
   output logic reg_rd_o,
   input wire mrs_pkg::mrs_word_t reg_data_i,
   // Coil state and busy flag
   output logic [31:0] coils_o,
   output logic run_cmd_o,
   output logic busy_o
);
   import mrs_pkg::*;

   // ----------------------------------------------------------------
   // Receive buffer
   // ----------------------------------------------------------------
   mrs_byte_t qbuf [0:7];
   logic [3:0] rx_count;
   mrs_word_t rx_crc;
   mrs_state_t state;
   logic frame_ok;

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_count <= 4'h0;
      end else if (frame_end_i || state != MRS_ST_IDLE) begin
         rx_count <= 4'h0;
      end else if (rx_valid_i && rx_count != 4'hf) begin
         rx_count <= rx_count + 4'h1;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int k = 0; k < 8; k++) begin
            qbuf[k] <= 8'h00;
         end
      end else if (state == MRS_ST_IDLE && rx_valid_i && !rx_count[3]) begin
         qbuf[rx_count[2:0]] <= rx_byte_i;
      end
   end

   mrs_crc16 u_rx_crc (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .clear_i(frame_end_i || state != MRS_ST_IDLE),
      .en_i(rx_valid_i),
      .data_i(rx_byte_i),
      .crc_o(rx_crc)
   );

   // Residue over data plus check word is zero for an intact frame
   assign frame_ok = (rx_count == `MRS_QUERY_LEN) && (rx_crc == 16'h0000)
      && (qbuf[0] != `MRS_BROADCAST)
      && (qbuf[0] == slave_addr_i);

   // ----------------------------------------------------------------
   // Query decode
   // ----------------------------------------------------------------
   mrs_byte_t fn;
   mrs_word_t q_addr;
   mrs_word_t q_data;
   mrs_word_t coil_num;
   mrs_resp_t next_kind;
   mrs_byte_t next_exc;
   mrs_byte_t next_len;
   mrs_byte_t next_bcnt;
   logic [31:0] next_packed;
   logic coil_wr;
   mrs_word_t pos;

   assign fn = qbuf[1];
   assign q_addr = {qbuf[2], qbuf[3]};
   assign q_data = {qbuf[4], qbuf[5]};
   assign coil_num = q_addr + 16'h0001;

   always_comb begin
      next_packed = 32'h0000_0000;
      for (int i = 0; i < 32; i++) begin
         pos = coil_num + 16'(i);
         // Positions past the count or the coil range stay zero
         if (16'(i) < q_data && pos <= `MRS_COIL_MAX) begin
            next_packed[i] = coils_o[pos[4:0]];
         end
      end
   end

   always_comb begin
      next_kind = MRS_RESP_EXC;
      next_exc = `MRS_EXC_FUNCTION;
      next_len = `MRS_EXC_LEN;
      next_bcnt = 8'h00;
      coil_wr = 1'b0;
      case (fn)
         `MRS_FN_READ_COILS: begin
            if (q_data == 16'h0000 || q_data > `MRS_COIL_MAX) begin
               next_exc = `MRS_EXC_FORMAT;
            end else begin
               next_kind = MRS_RESP_COIL;
               next_bcnt = 8'((q_data + 16'h0007) >> 3);
               next_len = `MRS_HDR_LEN + next_bcnt;
            end
         end
         `MRS_FN_READ_REGS: begin
            if (q_data == 16'h0000 || q_data > `MRS_REG_MAX) begin
               next_exc = `MRS_EXC_FORMAT;
            end else begin
               next_kind = MRS_RESP_REG;
               next_bcnt = 8'({q_data[14:0], 1'b0});
               next_len = `MRS_HDR_LEN + next_bcnt;
            end
         end
         `MRS_FN_WRITE_COIL: begin
            if (q_data != `MRS_COIL_ON && q_data != `MRS_COIL_OFF) begin
               next_exc = `MRS_EXC_FORMAT;
            end else if (coil_num > `MRS_COIL_MAX || coil_num == 16'h0000) begin
               next_exc = `MRS_EXC_NOT_FOUND;
            end else if (coil_num == `MRS_RUN_COIL
                  && run_command_source_select_i != `MRS_SRC_NETWORK) begin
               next_exc = `MRS_EXC_NOT_AVAIL;
            end else begin
               next_kind = MRS_RESP_ECHO;
               next_len = `MRS_ECHO_LEN;
               coil_wr = 1'b1;
            end
         end
         default: begin
            next_exc = `MRS_EXC_FUNCTION;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   mrs_resp_t kind;
   mrs_byte_t exc_code;
   mrs_byte_t body_len;
   mrs_byte_t bcnt;
   logic [31:0] packed_coils;
   mrs_byte_t idx;
   mrs_byte_t ld_idx;
   mrs_byte_t next_tx_byte;
   mrs_byte_t reg_lo;
   mrs_byte_t coil_ofs;
   mrs_word_t tx_crc;
   logic accept;
   logic load;
   logic last_byte;

   assign accept = tx_valid_o && tx_ready_i;
   assign last_byte = (idx == body_len + 8'h01);
   assign load = (state == MRS_ST_DECODE) || (accept && !last_byte);
   assign ld_idx = (state == MRS_ST_DECODE) ? 8'h00 : idx + 8'h01;
   assign busy_o = (state != MRS_ST_IDLE);

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= MRS_ST_IDLE;
      end else begin
         case (state)
            MRS_ST_IDLE: begin
               if (frame_end_i && frame_ok) begin
                  state <= MRS_ST_DECODE;
               end
            end
            MRS_ST_DECODE: begin
               state <= MRS_ST_SEND;
            end
            MRS_ST_SEND: begin
               if (accept && last_byte) begin
                  state <= MRS_ST_IDLE;
               end
            end
            default: begin
               state <= MRS_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         kind <= MRS_RESP_EXC;
         exc_code <= 8'h00;
         body_len <= 8'h00;
         bcnt <= 8'h00;
         packed_coils <= 32'h0000_0000;
      end else if (state == MRS_ST_DECODE) begin
         kind <= next_kind;
         exc_code <= next_exc;
         body_len <= next_len;
         bcnt <= next_bcnt;
         packed_coils <= next_packed;
      end
   end

   // ----------------------------------------------------------------
   // Coil store and run command
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         coils_o <= 32'h0000_0000;
      end else if (state == MRS_ST_DECODE && coil_wr) begin
         coils_o[coil_num[4:0]] <= (q_data == `MRS_COIL_ON);
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         run_cmd_o <= 1'b0;
      end else if (state == MRS_ST_DECODE && coil_wr && coil_num == `MRS_RUN_COIL) begin
         run_cmd_o <= (q_data == `MRS_COIL_ON);
      end
   end

   // ----------------------------------------------------------------
   // Reply byte generation
   // ----------------------------------------------------------------
   assign coil_ofs = ld_idx - `MRS_HDR_LEN;

   always_comb begin
      next_tx_byte = qbuf[0];
      if (ld_idx != 8'h00 && ld_idx == body_len) begin // Length is still stale while byte 0 loads
         next_tx_byte = tx_crc[7:0];
      end else if (ld_idx == body_len + 8'h01) begin
         next_tx_byte = tx_crc[15:8];
      end else if (ld_idx != 8'h00) begin
         case (kind)
            MRS_RESP_EXC: begin
               if (ld_idx == 8'h01) begin
                  next_tx_byte = fn | `MRS_FN_EXC_FLAG;
               end else begin
                  next_tx_byte = exc_code;
               end
            end
            MRS_RESP_ECHO: begin
               next_tx_byte = qbuf[ld_idx[2:0]];
            end
            MRS_RESP_COIL: begin
               if (ld_idx == 8'h01) begin
                  next_tx_byte = fn;
               end else if (ld_idx == 8'h02) begin
                  next_tx_byte = bcnt;
               end else begin
                  next_tx_byte = packed_coils[{coil_ofs[1:0], 3'b000} +: 8];
               end
            end
            MRS_RESP_REG: begin
               if (ld_idx == 8'h01) begin
                  next_tx_byte = fn;
               end else if (ld_idx == 8'h02) begin
                  next_tx_byte = bcnt;
               end else if (ld_idx[0]) begin
                  next_tx_byte = reg_data_i[15:8];
               end else begin
                  next_tx_byte = reg_lo;
               end
            end
            default: begin
               next_tx_byte = qbuf[0];
            end
         endcase
      end
   end

   // Register read strobed as each word's high byte is loaded
   assign reg_rd_o = (state == MRS_ST_SEND) && load && kind == MRS_RESP_REG
      && ld_idx >= `MRS_HDR_LEN && ld_idx < body_len && ld_idx[0];

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reg_addr_o <= 16'h0000;
         reg_lo <= 8'h00;
      end else if (state == MRS_ST_DECODE) begin
         reg_addr_o <= coil_num;
      end else if (reg_rd_o) begin
         reg_lo <= reg_data_i[7:0];
         reg_addr_o <= reg_addr_o + 16'h0001;
      end
   end

   mrs_crc16 u_tx_crc (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .clear_i(state == MRS_ST_IDLE),
      .en_i(load && (ld_idx == 8'h00 || ld_idx < body_len)),
      .data_i(next_tx_byte),
      .crc_o(tx_crc)
   );

   // Check word always loads at least a cycle after the last body byte, so the engine is settled
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tx_valid_o <= 1'b0;
         tx_byte_o <= 8'h00;
         tx_last_o <= 1'b0;
         idx <= 8'h00;
      end else if (load) begin
         tx_valid_o <= 1'b1;
         tx_byte_o <= next_tx_byte;
         tx_last_o <= (state != MRS_ST_DECODE) && (ld_idx == body_len + 8'h01);
         idx <= ld_idx;
      end else if (accept) begin
         tx_valid_o <= 1'b0;
         tx_last_o <= 1'b0;
      end
   end
endmodule : mrs_slave
`default_nettype wire

//--- sim/mrs_slave_props.sv
// Concurrent checks on the query interpreter ports
`timescale 1ns/1ps
`default_nettype none
module mrs_slave_props (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Query side
   input wire mrs_pkg::mrs_byte_t slave_addr_i,
   input wire mrs_pkg::mrs_byte_t rx_byte_i,
   input wire logic rx_valid_i,
   input wire logic frame_end_i,
   // Reply side
   input wire mrs_pkg::mrs_byte_t tx_byte_o,
   input wire logic tx_valid_o,
   input wire logic tx_last_o,
   input wire logic tx_ready_i,
   input wire mrs_pkg::mrs_word_t reg_addr_o,
   input wire logic reg_rd_o,
   input wire logic [31:0] coils_o,
   input wire logic busy_o
);
   import mrs_pkg::*;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);
   // ----------------------------------------
   // First byte of the frame in flight
   // ----------------------------------------
   logic in_fr;
   mrs_byte_t fb;
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         in_fr <= 1'b0;
         fb <= 8'h00;
      end else if (frame_end_i) begin
         in_fr <= 1'b0;
      end else if (rx_valid_i && !in_fr) begin
         in_fr <= 1'b1;
         fb <= rx_byte_i;
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_byte_held: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
      else $error("reply byte changed before acceptance");
   a_last_ends: assert property (tx_valid_o && tx_ready_i && tx_last_o |=> !tx_valid_o && !busy_o)
      else $error("reply did not end after last byte");
   a_busy_holds: assert property (busy_o && !(tx_valid_o && tx_ready_i && tx_last_o) |=> busy_o)
      else $error("busy dropped mid reply");
   a_busy_leads: assert property ($rose(busy_o) |=> tx_valid_o)
      else $error("reply did not start after decode");
   a_first_addr: assert property ($rose(tx_valid_o) |-> tx_byte_o == slave_addr_i)
      else $error("reply does not open with own address");
   a_bcast_silent: assert property (frame_end_i && !busy_o && fb == 8'h00 |=> !busy_o [*3])
      else $error("broadcast query accepted");
   a_other_silent: assert property (frame_end_i && !busy_o && fb != slave_addr_i |=> !busy_o [*3])
      else $error("foreign address accepted");
   a_reg_step: assert property (reg_rd_o |=> reg_addr_o == $past(reg_addr_o) + 16'h0001)
      else $error("register number did not step");
   a_reg_busy: assert property (reg_rd_o |-> busy_o && !tx_last_o)
      else $error("register read outside reply body");
   a_coil0_zero: assert property (coils_o[0] == 1'b0)
      else $error("coil zero set");
   cover property (reg_rd_o);
   cover property (tx_valid_o && !tx_ready_i);
   cover property (tx_valid_o && tx_ready_i && tx_last_o);
endmodule : mrs_slave_props

bind mrs_slave mrs_slave_props i_mrs_slave_props (.mclk_i(mclk_i), .nrst_i(nrst_i),
   .slave_addr_i(slave_addr_i), .rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i),
   .frame_end_i(frame_end_i), .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o), .tx_last_o(tx_last_o),
   .tx_ready_i(tx_ready_i), .reg_addr_o(reg_addr_o), .reg_rd_o(reg_rd_o), .coils_o(coils_o),
   .busy_o(busy_o));
`default_nettype wire

//--- sim/mrs_master.sv
// Network master model: sends queries, takes reply bytes
`timescale 1ns/1ps
`default_nettype none
module mrs_master (
   // Clock
   input wire logic mclk_i,
   // Query stream
   output mrs_pkg::mrs_byte_t q_byte_o,
   output logic q_valid_o,
   output logic q_end_o,
   // Reply stream
   input wire mrs_pkg::mrs_byte_t r_byte_i,
   input wire logic r_valid_i,
   input wire logic r_last_i,
   output logic ready_o
);
   import mrs_pkg::*;
   initial begin
      q_byte_o = 8'h00;
      q_valid_o = 1'b0;
      q_end_o = 1'b0;
      ready_o = 1'b0;
   end
   // Whole frame, then end pulse; released data shows inverse
   task automatic send(input mrs_byte_t q[$]);
      foreach (q[i]) begin
         q_byte_o = q[i];
         q_valid_o = 1'b1;
         @(posedge mclk_i);
         #1;
      end
      q_valid_o = 1'b0;
      q_byte_o = ~q_byte_o;
      q_end_o = 1'b1;
      @(posedge mclk_i);
      #1;
      q_end_o = 1'b0;
   endtask : send
   // Stalling sink toggles ready every cycle
   task automatic take(input bit st, output mrs_byte_t r[$]);
      bit done;
      r = {};
      done = 1'b0;
      for (int n = 0; n < 200 && !done; n++) begin
         ready_o = !st || n[0];
         @(posedge mclk_i);
         if (r_valid_i && ready_o) begin
            r.push_back(r_byte_i);
            done = r_last_i;
         end
         #1;
      end
      ready_o = 1'b0;
   endtask : take
endmodule : mrs_master
`default_nettype wire

//--- sim/mrs_slave_tb.sv
// Self-checking bench for the query interpreter
`timescale 1ns/1ps
`default_nettype none
module mrs_slave_tb;
   import mrs_pkg::*;
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   mrs_byte_t sa = 8'h08;
   mrs_byte_t src = 8'h00;
   mrs_byte_t rxb, txb;
   logic rxv, fe, txv, txl, rdy, rd, run, busy_o;
   mrs_word_t ra;
   logic [31:0] coils;
   mrs_byte_t eq[$];
   int mismatches = 0;
   int cmp_count = 0;
   // Register contents derived from register number
   wire mrs_word_t rdat = {ra[7:0], ~ra[7:0]};
   always #50 mclk_i = ~mclk_i;
   mrs_slave i_mrs_slave (.mclk_i(mclk_i), .nrst_i(nrst_i), .slave_addr_i(sa),
      .run_command_source_select_i(src), .rx_byte_i(rxb), .rx_valid_i(rxv), .frame_end_i(fe),
      .tx_byte_o(txb), .tx_valid_o(txv), .tx_last_o(txl), .tx_ready_i(rdy), .reg_addr_o(ra),
      .reg_rd_o(rd), .reg_data_i(rdat), .coils_o(coils), .run_cmd_o(run), .busy_o(busy_o));
   mrs_master i_mrs_master (.mclk_i(mclk_i), .q_byte_o(rxb), .q_valid_o(rxv), .q_end_o(fe),
      .r_byte_i(txb), .r_valid_i(txv), .r_last_i(txl), .ready_o(rdy));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   function automatic mrs_word_t crc16(input mrs_byte_t q[$]);
      mrs_word_t c;
      c = 16'hffff;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
      return c;
   endfunction : crc16
   // Send one query, compare reply with eq plus its check word
   task automatic xact(input mrs_byte_t ad, fn, input mrs_word_t a, d, input bit st, bad);
      mrs_byte_t q[$];
      mrs_byte_t r[$];
      mrs_word_t c;
      q = {ad, fn, a[15:8], a[7:0], d[15:8], d[7:0]};
      c = crc16(q);
      q.push_back(c[7:0]);
      q.push_back(c[15:8] ^ {7'h00, bad});
      i_mrs_master.send(q);
      i_mrs_master.take(st, r);
      if (eq.size() > 0) begin
         c = crc16(eq);
         eq.push_back(c[7:0]);
         eq.push_back(c[15:8]);
      end
      @(posedge mclk_i);
      #1;
      chk("reply length", r.size(), eq.size());
      foreach (eq[i]) if (i < r.size()) chk("reply byte", r[i], eq[i]);
      chk("busy", busy_o, 1'b0);
      eq = {};
   endtask : xact
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_coils;
      eq = {8'h08, 8'h05, 8'h00, 8'h06, 8'hff, 8'h00};
      xact(8'h08, 8'h05, 16'h0006, 16'hff00, 1'b0, 1'b0);
      chk("coil 7", coils[7], 1'b1);
      eq = {8'h08, 8'h05, 8'h00, 8'h08, 8'hff, 8'h00};
      xact(8'h08, 8'h05, 16'h0008, 16'hff00, 1'b0, 1'b0);
      eq = {8'h08, 8'h05, 8'h00, 8'h1e, 8'hff, 8'h00};
      xact(8'h08, 8'h05, 16'h001e, 16'hff00, 1'b1, 1'b0);
      eq = {8'h08, 8'h01, 8'h01, 8'h05};
      xact(8'h08, 8'h01, 16'h0006, 16'h0005, 1'b1, 1'b0);
      eq = {8'h08, 8'h01, 8'h02, 8'h20, 8'h00};
      xact(8'h08, 8'h01, 16'h0019, 16'h000a, 1'b0, 1'b0);
      eq = {8'h08, 8'h01, 8'h04, 8'h40, 8'h01, 8'h00, 8'h40};
      xact(8'h08, 8'h01, 16'h0000, 16'h001f, 1'b0, 1'b0);
      eq = {8'h08, 8'h05, 8'h00, 8'h06, 8'h00, 8'h00};
      xact(8'h08, 8'h05, 16'h0006, 16'h0000, 1'b0, 1'b0);
      chk("coil 7 off", coils[7], 1'b0);
      $display("test coils done");
   endtask : t_coils
   task automatic t_exc;
      mrs_byte_t fn[9] = '{8'h01, 8'h01, 8'h04, 8'h03, 8'h05, 8'h05, 8'h05, 8'h05, 8'h03};
      mrs_word_t ad[9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0006,
         16'h0000, 16'hffff, 16'h001f, 16'h0000};
      mrs_word_t dt[9] = '{16'h0000, 16'h0020, 16'h0001, 16'h0000, 16'h1234,
         16'hff00, 16'hff00, 16'hff00, 16'h007e};
      mrs_byte_t cd[9] = '{8'h03, 8'h03, 8'h01, 8'h03, 8'h03, 8'h22, 8'h02, 8'h02, 8'h03};
      for (int i = 0; i < 9; i++) begin
         eq = {8'h08, fn[i] | 8'h80, cd[i]};
         xact(8'h08, fn[i], ad[i], dt[i], 1'b0, 1'b0);
      end
      chk("run blocked", run, 1'b0);
      chk("coil 1 blocked", coils[1], 1'b0);
      chk("coil 0 kept", coils[0], 1'b0);
      $display("test exceptions done");
   endtask : t_exc
   task automatic t_regs;
      eq = {8'h08, 8'h03, 8'h06, 8'h12, 8'hed, 8'h13, 8'hec, 8'h14, 8'heb};
      xact(8'h08, 8'h03, 16'h0011, 16'h0003, 1'b1, 1'b0);
      $display("test registers done");
   endtask : t_regs
   task automatic t_run;
      src = 8'h03;
      eq = {8'h08, 8'h05, 8'h00, 8'h00, 8'hff, 8'h00};
      xact(8'h08, 8'h05, 16'h0000, 16'hff00, 1'b0, 1'b0);
      chk("run on", run, 1'b1);
      eq = {8'h08, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
      xact(8'h08, 8'h05, 16'h0000, 16'h0000, 1'b0, 1'b0);
      chk("run off", run, 1'b0);
      $display("test run done");
   endtask : t_run
   task automatic t_silent;
      xact(8'h00, 8'h05, 16'h0006, 16'hff00, 1'b0, 1'b0);
      chk("broadcast write", coils[7], 1'b0);
      xact(8'h09, 8'h01, 16'h0000, 16'h0001, 1'b0, 1'b0);
      xact(8'h08, 8'h01, 16'h0000, 16'h0001, 1'b0, 1'b1);
      $display("test silent done");
   endtask : t_silent
   // ----------------------------------------
   // Run control
   // ----------------------------------------
   task automatic end_sim;
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      repeat (3) @(posedge mclk_i);
      #1;
      nrst_i = 1'b1;
      @(posedge mclk_i);
      #1;
      t_coils();
      t_exc();
      t_regs();
      t_run();
      t_silent();
      end_sim();
   end
   // 22 queries of at most 210 cycles each
   initial begin
      #2ms;
      mismatches++;
      end_sim();
   end
endmodule : mrs_slave_tb
`default_nettype wire
